// ### dv/conv_core_model.sv
// Converter core stand-in: hands back a sample coded by the selected channel.
// Assumes the control block holds conv_active high while it converts.
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] channel_sel,
  input  wire logic       conv_active,
  output logic [9:0]      sample_in
);
  logic [9:0] junk_q = 10'h155;
  // Outside a conversion the value churns, so a capture at the wrong time shows.
  always @(posedge ref_clk) junk_q <= ~junk_q + 10'h001;
  assign sample_in = conv_active ? {channel_sel, 8'h5A ^ {4{channel_sel}}} : junk_q;
endmodule : conv_core_model

// ### dv/tb_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes the core model beside it feeds sample_in from channel_sel.
`timescale 1ns/1ps
module tb_adc_conversion_control;
  import adc_ctrl_pkg::*;
  logic       ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic [9:0] sample_in;
  logic [1:0] channel_sel;
  logic       conv_active, irq;
  int         error_cnt = 0, comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  adc_conversion_control dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_start_pin(pin),
    .sample_in(sample_in), .channel_sel(channel_sel), .conv_active(conv_active), .irq(irq));
  conv_core_model core (.ref_clk(ref_clk), .channel_sel(channel_sel), .conv_active(conv_active),
    .sample_in(sample_in));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    // Let the write settle before callers look at the outputs it changes.
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
  endtask : rd
  task automatic wait_idle();
    int n = 0;
    while (conv_active !== 1'b0)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 300)
      begin
        chk("conversion end", 8'h01, 8'h00);
        close_out();
      end
    end
    repeat (2) @(negedge ref_clk);
  endtask : wait_idle
  function automatic logic [9:0] smp(input logic [1:0] c);
    return {c, 8'h5A ^ {4{c}}};
  endfunction : smp
  function automatic logic [1:0] smp_lo(input logic [1:0] c);
    logic [9:0] s;
    s = smp(c);
    return s[1:0];
  endfunction : smp_lo
  function automatic logic [7:0] smp_hi(input logic [1:0] c);
    logic [9:0] s;
    s = smp(c);
    return s[9:2];
  endfunction : smp_hi
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd(CTRL_STATUS_ADDR);
    chk("ctrl reset", rv, CTRL_RESET);
    rd(RESULT_UPPER_ADDR);
    chk("result reset", rv, RESULT_RESET);
    wr(8'h7F, 8'hFF);
    rd(8'h7F);
    chk("unmapped read", rv, 8'h00);
    chk("irq reset", irq, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_soft();
    wr(CTRL_STATUS_ADDR, 8'h02);
    chk("channel", channel_sel, 2'd2);
    wr(CTRL_STATUS_ADDR, 8'h0A);
    @(negedge ref_clk);
    chk("started", conv_active, 1'b1);
    wait_idle();
    rd(CTRL_STATUS_ADDR);
    chk("ctrl done", rv, {smp_lo(2'd2), 6'h12});
    rd(RESULT_UPPER_ADDR);
    chk("result upper", rv, smp_hi(2'd2));
    chk("irq masked", irq, 1'b0);
    rd(IRQ_STATUS_ADDR);
    chk("irq status", rv, 8'h01);
    wr(IRQ_MASK_ADDR, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk("irq raised", irq, 1'b1);
    wr(IRQ_STATUS_ADDR, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk("irq cleared", irq, 1'b0);
    $display("test soft done");
  endtask : t_soft
  task automatic t_refuse();
    wr(CTRL_STATUS_ADDR, 8'h19);
    repeat (2) @(negedge ref_clk);
    chk("start while done", conv_active, 1'b0);
    chk("channel while done", channel_sel, 2'd2);
    rd(CTRL_STATUS_ADDR);
    chk("ctrl kept", rv, {smp_lo(2'd2), 6'h12});
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_restart();
    // Done cleared and start set in one write.
    wr(CTRL_STATUS_ADDR, 8'h0A);
    @(negedge ref_clk);
    chk("restart", conv_active, 1'b1);
    wr(CTRL_STATUS_ADDR, 8'h09);
    @(negedge ref_clk);
    chk("channel while busy", channel_sel, 2'd2);
    chk("still busy", conv_active, 1'b1);
    wait_idle();
    chk("irq on done", irq, 1'b1);
    wr(IRQ_STATUS_ADDR, 8'h01);
    wr(CTRL_STATUS_ADDR, 8'h02);
    rd(CTRL_STATUS_ADDR);
    chk("done cleared", rv, {smp_lo(2'd2), 6'h02});
    $display("test restart done");
  endtask : t_restart
  task automatic t_abort();
    wr(CTRL_STATUS_ADDR, 8'h0A);
    repeat (10) @(negedge ref_clk);
    wr(CTRL_STATUS_ADDR, 8'h02);
    @(negedge ref_clk);
    chk("aborted", conv_active, 1'b0);
    repeat (CONV_CYCLES + 20) @(negedge ref_clk);
    rd(CTRL_STATUS_ADDR);
    chk("no done", rv, {smp_lo(2'd2), 6'h02});
    rd(IRQ_STATUS_ADDR);
    chk("no irq status", rv, 8'h00);
    $display("test abort done");
  endtask : t_abort
  task automatic t_ext();
    @(posedge ref_clk);
    pin <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("pin ignored", conv_active, 1'b0);
    pin <= 1'b0;
    wr(CTRL_STATUS_ADDR, 8'h23);
    chk("channel 3", channel_sel, 2'd3);
    @(posedge ref_clk);
    pin <= 1'b1;
    @(negedge ref_clk);
    chk("pin synchronised", conv_active, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk("pin start", conv_active, 1'b1);
    wait_idle();
    rd(CTRL_STATUS_ADDR);
    chk("ext done", rv, {smp_lo(2'd3), 6'h33});
    rd(RESULT_UPPER_ADDR);
    chk("ext result", rv, smp_hi(2'd3));
    pin <= 1'b0;
    wr(IRQ_STATUS_ADDR, 8'h01);
    wr(CTRL_STATUS_ADDR, 8'h20);
    // Software may not set the done flag.
    wr(CTRL_STATUS_ADDR, 8'h10);
    rd(CTRL_STATUS_ADDR);
    chk("done not settable", rv, {smp_lo(2'd3), 6'h00});
    chk("channel 0", channel_sel, 2'd0);
    chk("irq idle", irq, 1'b0);
    $display("test ext done");
  endtask : t_ext
  initial
  begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_soft();
    t_refuse();
    t_restart();
    t_abort();
    t_ext();
    close_out();
  end
endmodule : tb_adc_conversion_control

// ### hdl/adc_conversion_control.sv
// Converter control and status: start, abort, channel select, result store.
// Assumes synchronous inputs apart from external_start_pin; the converter core delivers its sample on
// the conv_finish cycle, the last one in ST_CONV, through sample_in.
`timescale 1ns/1ps
module adc_conversion_control (
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    external_start_pin,
  input  wire logic [9:0]              sample_in,
  output logic [1:0]                   channel_sel,
  output logic                         conv_active,
  output logic                         irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    conv_state_t st;
    logic        external_trigger_enable;
    logic        conversion_done_flag;
    logic        start_busy_bit;
    logic        clksel;
    logic [1:0]  chan;
    logic [9:0]  result;
    logic        irq_stat;
    logic        irq_mask;
    logic [7:0]  rdata;
  } ctl_t;

  ctl_t c_q;
  ctl_t c_d;

  logic ext_rise;
  logic conv_finish;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic sw_start;
  logic sw_clear_busy;
  logic start_req;
  logic can_start;
  logic [7:0] ctrl_view;

  start_edge_sync u_sync (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .pin_in     (external_start_pin),
    .rise_pulse (ext_rise)
  );

  conv_timer u_tmr (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (c_q.st == ST_CONV),
    .finish  (conv_finish)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign wr_ctrl  = reg_wr && (reg_addr == CTRL_STATUS_ADDR);
  assign wr_istat = reg_wr && (reg_addr == IRQ_STATUS_ADDR);
  assign wr_imask = reg_wr && (reg_addr == IRQ_MASK_ADDR);

  // Starts are judged against the flags as they stand before this write,
  // except that a done clear in the same write may release a start.
  assign sw_start      = wr_ctrl && reg_wdata[BUSY_POS];
  assign sw_clear_busy = wr_ctrl && !reg_wdata[BUSY_POS] && c_q.start_busy_bit;
  assign start_req     = sw_start || (ext_rise && c_q.external_trigger_enable);
  assign can_start     = !c_q.start_busy_bit
                         && (!c_q.conversion_done_flag
                             || (wr_ctrl && !reg_wdata[DONE_POS]));

  always_comb
  begin
    ctrl_view                = CTRL_RESET;
    ctrl_view[RES_LO_HI_POS] = c_q.result[1];
    ctrl_view[RES_LO_LO_POS] = c_q.result[0];
    ctrl_view[EXT_EN_POS]    = c_q.external_trigger_enable;
    ctrl_view[DONE_POS]      = c_q.conversion_done_flag;
    ctrl_view[BUSY_POS]      = c_q.start_busy_bit;
    ctrl_view[CLKSEL_POS]    = c_q.clksel;
    ctrl_view[CHAN_HI_POS]   = c_q.chan[1];
    ctrl_view[CHAN_LO_POS]   = c_q.chan[0];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    c_d = c_q;

    // Read data for the cycle after the strobe; unmapped reads give zero.
    c_d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        CTRL_STATUS_ADDR:  c_d.rdata = ctrl_view;
        RESULT_UPPER_ADDR: c_d.rdata = c_q.result[9:2];
        IRQ_STATUS_ADDR:   c_d.rdata = {7'h00, c_q.irq_stat};
        IRQ_MASK_ADDR:     c_d.rdata = {7'h00, c_q.irq_mask};
        default:           c_d.rdata = 8'h00;
      endcase
    end

    if (wr_ctrl)
    begin
      c_d.external_trigger_enable = reg_wdata[EXT_EN_POS];
      c_d.clksel                  = reg_wdata[CLKSEL_POS];
      // Software may only clear the done flag, never set it.
      if (!reg_wdata[DONE_POS])
        c_d.conversion_done_flag = 1'b0;
      if (!c_q.conversion_done_flag && !c_q.start_busy_bit)
        c_d.chan = {reg_wdata[CHAN_HI_POS], reg_wdata[CHAN_LO_POS]};
    end
    if (wr_imask)
      c_d.irq_mask = reg_wdata[0];
    if (wr_istat && reg_wdata[0])
      c_d.irq_stat = 1'b0;

    case (c_q.st)
      ST_IDLE:
      begin
        if (start_req && can_start)
        begin
          c_d.st             = ST_CONV;
          c_d.start_busy_bit = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (sw_clear_busy)
        begin
          c_d.st             = ST_IDLE;
          c_d.start_busy_bit = 1'b0;
        end
        else if (conv_finish)
        begin
          c_d.st                   = ST_DONE;
          c_d.result               = sample_in;
          c_d.conversion_done_flag = 1'b1;
        end
      end
      ST_DONE:
      begin
        // One-cycle 1/1 transient, then busy drops.
        c_d.start_busy_bit = 1'b0;
        c_d.st             = ST_IDLE;
      end
      default:
        c_d.st = ST_IDLE;
    endcase

    // Set wins over a same-cycle clear.
    if (c_q.st == ST_CONV && conv_finish && !sw_clear_busy)
      c_d.irq_stat = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      c_q <= '{st: ST_IDLE, result: 10'h000, rdata: 8'h00, chan: 2'b00, default: 1'b0};
    else
      c_q <= c_d;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata   = c_q.rdata;
  assign channel_sel = c_q.chan;
  assign conv_active = (c_q.st == ST_CONV);
  assign irq         = c_q.irq_stat & c_q.irq_mask;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  no_start_blocked_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (c_q.st != ST_CONV && c_q.start_busy_bit) |=> (c_q.st != ST_CONV))
    else $error("conversion started while busy");

  busy_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(c_q.conversion_done_flag) |-> c_q.start_busy_bit ##1 !c_q.start_busy_bit)
    else $error("busy not cleared right after done");

  abort_now_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (conv_active && sw_clear_busy) |=> (!conv_active && !c_q.start_busy_bit && !c_q.conversion_done_flag))
    else $error("abort did not stop the conversion");

  sw_no_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!c_q.conversion_done_flag && !(conv_active && conv_finish)) |=> !c_q.conversion_done_flag)
    else $error("done flag set without a result");

  ext_ignored_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (c_q.st == ST_IDLE && !c_q.external_trigger_enable && !sw_start) |=> c_q.st != ST_CONV)
    else $error("external pin started a disabled conversion");

  ext_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (c_q.st == ST_IDLE && ext_rise && c_q.external_trigger_enable && can_start)
      |=> (conv_active && c_q.start_busy_bit))
    else $error("enabled external edge did not start");

  chan_locked_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (c_q.start_busy_bit || c_q.conversion_done_flag) |=> $stable(c_q.chan))
    else $error("channel changed while not idle");

  result_with_done_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(c_q.conversion_done_flag) |-> (c_q.result == $past(sample_in)))
    else $error("result not stored with done flag");

  conv_length_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(conv_active) |-> conv_active [*2])
    else $error("conversion shorter than expected");

endmodule : adc_conversion_control

// ### hdl/conv_timer.sv
// Conversion timer: counts the converter's fixed conversion time.
// Assumes the caller holds run high for the whole conversion.
`timescale 1ns/1ps
module conv_timer (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      finish
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } tmr_t;

  tmr_t t_q;
  tmr_t t_d;

  always_comb
  begin
    t_d = t_q;
    if (!run)
      t_d.cnt = 8'h00;
    else if (t_q.cnt != CONV_LAST)
      t_d.cnt = t_q.cnt + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign finish = run && (t_q.cnt == CONV_LAST);

endmodule : conv_timer

// ### hdl/start_edge_sync.sv
// Two-stage synchroniser with rising-edge detector for the start pin.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module start_edge_sync (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      rise_pulse
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Only the second and third stages feed the edge test.
  assign rise_pulse = s_q.sync & ~s_q.prev;

  edge_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst) rise_pulse |=> !rise_pulse)
    else $error("start edge pulse longer than one cycle");

endmodule : start_edge_sync

// ### include/adc_ctrl_pkg.sv
// Constants and types shared by the converter control block.
// Assumes a plain register port: address, write data, write and read strobes.
//
// Overview of operation
// - Writing one to start/busy starts a conversion.
// - External pin ignored while external trigger disabled.
// - Enabled pin rising edge starts and sets busy.
// - Done flag set on result; interrupt if enabled.
// - Software cannot set the done flag.
// - No new start while busy, or while done unless the same write clears it.
// - Busy holds during conversion, clears after done.
// - Software clearing busy aborts the conversion.
// - Channel field selects one of four inputs.
// - Channel writable only while idle.
// - Result split: upper eight, lower two in control.
// - Done/busy pair encodes idle, busy, complete, transient.
package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'hE1;
  localparam logic [7:0] RESULT_UPPER_ADDR = 8'hE2;
  localparam logic [7:0] IRQ_STATUS_ADDR  = 8'hE3;
  localparam logic [7:0] IRQ_MASK_ADDR    = 8'hE4;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int RES_LO_HI_POS = 7;
  localparam int RES_LO_LO_POS = 6;
  localparam int EXT_EN_POS    = 5;
  localparam int DONE_POS      = 4;
  localparam int BUSY_POS      = 3;
  localparam int CLKSEL_POS    = 2;
  localparam int CHAN_HI_POS   = 1;
  localparam int CHAN_LO_POS   = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int CONV_TIME_NS    = 2000;
  localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DONE
  } conv_state_t;

endpackage : adc_ctrl_pkg
